// file: verilog/instrument_error_queue.sv
`timescale 1ns/1ps
`default_nettype none
`include "error_queue_cfg.svh"

// Summary of operation
// - records leave in arrival order, oldest first.
// - each query outside a clear-status cycle returns one record and removes it.
// - empty queue answers code zero with the no-error message.
// - error arriving with twenty stored and no read in the same cycle overwrites newest with overflow code -350.
// - after overflow, new errors dropped until one record is read.
// - power-up reset and clear-status empty the queue.
// - reset command leaves contents and read position alone.
// - record is signed code plus message index; text read out one character at a time, up to 80 characters.
module instrument_error_queue (
  input  wire logic                          ref_clk_i,
  input  wire logic                          reset_n_i,
  input  wire logic                          clk_en_i,
  input  wire logic                          err_valid_i,
  input  wire error_queue_pkg::err_code_t    err_code_i,
  input  wire error_queue_pkg::msg_idx_t     err_msg_i,
  input  wire logic                          query_i,
  input  wire logic                          clear_status_i,
  input  wire logic                          reset_cmd_i,
  input  wire logic [6:0]                    char_pos_i,
  output logic                               resp_valid_o,
  output error_queue_pkg::err_code_t         resp_code_o,
  output error_queue_pkg::msg_idx_t          resp_msg_o,
  output logic [7:0]                         resp_char_o,
  output logic [6:0]                         resp_len_o,
  output logic [4:0]                         count_o,
  output logic                               full_o,
  output logic                               empty_o
);

  // ==========================================================
  // state
  typedef struct packed {
    error_queue_pkg::err_code_t [19:0] code;
    error_queue_pkg::msg_idx_t  [19:0] msg;
    error_queue_pkg::ptr_t             wr;
    error_queue_pkg::ptr_t             rd;
    logic [4:0]                        cnt;
    logic                              ovf;
    logic                              rv;
    error_queue_pkg::err_code_t        rc;
    error_queue_pkg::msg_idx_t         rm;
    logic [7:0]                        ch;
    logic [6:0]                        ln;
    logic                              full;
    logic                              empty;
  } state_s;

  state_s q, d;
  logic [7:0] rom_char;
  logic [6:0] rom_len;

  function automatic error_queue_pkg::ptr_t inc(input error_queue_pkg::ptr_t p);
    inc = (p == `EQ_DEPTH - 5'd1) ? `EQ_PTR_RST : p + 5'd1;
  endfunction : inc

  function automatic error_queue_pkg::ptr_t dec(input error_queue_pkg::ptr_t p);
    dec = (p == `EQ_PTR_RST) ? `EQ_DEPTH - 5'd1 : p - 5'd1;
  endfunction : dec

  // text lookup for the record being answered
  error_text_rom u_text (
    .msg_idx_i  (q.rm),
    .char_pos_i (char_pos_i),
    .char_o     (rom_char),
    .len_o      (rom_len)
  );

  wire logic is_full  = q.full;
  wire logic is_empty = q.empty;

  // ==========================================================
  // next state
  always_comb begin
    d = q;
    d.rv = 1'b0;
    d.ch = rom_char;
    d.ln = rom_len;
    // reset_cmd_i deliberately not used: queue survives it
    if (clear_status_i) begin
      d.wr  = `EQ_PTR_RST;
      d.rd  = `EQ_PTR_RST;
      d.cnt = 5'd0;
      d.ovf = 1'b0;
    end else begin
      if (query_i) begin
        d.rv = 1'b1;
        if (is_empty) begin
          d.rc = `EQ_CODE_NONE;
          d.rm = `EQ_MSG_NONE;
        end else begin
          d.rc  = q.code[q.rd];
          d.rm  = q.msg[q.rd];
          d.rd  = inc(q.rd);
          d.cnt = q.cnt - 5'd1;
          d.ovf = 1'b0;
        end
      end
      if (err_valid_i) begin
        if (!is_full || (query_i && !is_empty)) begin
          // a read in the same cycle frees a slot, so store normally
          d.code[q.wr] = err_code_i;
          d.msg[q.wr]  = err_msg_i;
          d.wr  = inc(q.wr);
          d.cnt = d.cnt + 5'd1;
        end else if (!q.ovf) begin
          d.code[dec(q.wr)] = `EQ_CODE_OVERFLOW;
          d.msg[dec(q.wr)]  = `EQ_MSG_OVERFLOW;
          d.ovf = 1'b1;
        end
        // otherwise dropped while overflowed
      end
    end
    // flags kept in flip-flops so full_o and empty_o leave a register
    d.full  = (d.cnt == `EQ_DEPTH);
    d.empty = (d.cnt == 5'd0);
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q <= '0;
      q.empty <= `EQ_EMPTY_RST;
    end else if (clk_en_i) begin
      q <= d;
    end
  end

  assign resp_valid_o = q.rv;
  assign resp_code_o  = q.rc;
  assign resp_msg_o   = q.rm;
  assign resp_char_o  = q.ch;
  assign resp_len_o   = q.ln;
  assign count_o      = q.cnt;
  assign full_o       = is_full;
  assign empty_o      = is_empty;

  // ==========================================================
  // checks
  a_empty_answer: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    clk_en_i && query_i && is_empty && !clear_status_i |=>
      resp_valid_o && resp_code_o == `EQ_CODE_NONE && resp_msg_o == `EQ_MSG_NONE)
    else $error("empty query did not return no-error");
  a_query_pops: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    clk_en_i && query_i && !is_empty && !err_valid_i && !clear_status_i |=>
      count_o == $past(count_o) - 5'd1)
    else $error("query did not remove one record");
  a_fifo_order: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    clk_en_i && query_i && !is_empty && !clear_status_i |=>
      resp_code_o == $past(q.code[q.rd]))
    else $error("record returned out of order");
  a_overflow_mark: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    clk_en_i && err_valid_i && is_full && !q.ovf && !query_i && !clear_status_i |=>
      q.code[dec(q.wr)] == `EQ_CODE_OVERFLOW && full_o)
    else $error("overflow code not placed");
  a_drop_after: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    clk_en_i && q.ovf && !query_i && !clear_status_i |=> $stable(q.code) && q.ovf)
    else $error("error stored while overflowed");
  a_clear_empty: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    clk_en_i && clear_status_i |=> empty_o && count_o == 5'd0)
    else $error("clear status left entries");
  a_reset_keep: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    clk_en_i && reset_cmd_i && !query_i && !err_valid_i && !clear_status_i |=>
      $stable(count_o) && $stable(q.rd))
    else $error("reset command disturbed queue");
  a_count_bound: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    count_o <= `EQ_DEPTH && full_o == (count_o == `EQ_DEPTH) && empty_o == (count_o == 5'd0))
    else $error("count out of range");
  a_text_len: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    resp_len_o <= `EQ_CHAR_MAX)
    else $error("message longer than limit");

  // ==========================================================
  // answer steps: query taken, record shown, text one cycle later
  sequence s_query_taken;
    clk_en_i && query_i && !clear_status_i;
  endsequence

  sequence s_text_settled;
    s_query_taken ##1 clk_en_i;
  endsequence

  // length and character both come from the same registered index
  sequence s_beyond_text;
    clk_en_i ##1 ($past(char_pos_i) >= resp_len_o);
  endsequence

  sequence s_overflow_hit;
    clk_en_i && err_valid_i && is_full && !q.ovf && !query_i && !clear_status_i;
  endsequence

  a_answer_pulse: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    s_query_taken |=> resp_valid_o)
    else $error("query got no answer");
  a_valid_single: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    clk_en_i && resp_valid_o && !query_i |=> !resp_valid_o)
    else $error("answer stood longer than one cycle");
  a_empty_read: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    clk_en_i && query_i && is_empty && !err_valid_i && !clear_status_i |=>
      empty_o && count_o == 5'd0)
    else $error("query on empty queue changed count");
  a_store_count: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    clk_en_i && err_valid_i && !is_full && !query_i && !clear_status_i |=>
      count_o == $past(count_o) + 5'd1)
    else $error("stored error not counted");

  // overflow mark must stay until a read frees a slot
  a_overflow_hold: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    s_overflow_hit |=> count_o == `EQ_DEPTH && q.ovf)
    else $error("overflow changed the count");
  a_ovf_release: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    clk_en_i && q.ovf && query_i && !is_empty && !clear_status_i |=> !q.ovf)
    else $error("overflow not released by a read");

  a_text_ready: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    s_text_settled |=> resp_len_o != 7'h00 && resp_len_o <= `EQ_CHAR_MAX)
    else $error("message length missing after answer");
  a_text_pad: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    s_beyond_text |-> resp_char_o == `EQ_CHAR_PAD)
    else $error("character beyond message not padded");
  a_freeze_hold: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !clk_en_i |=> $stable(q))
    else $error("state moved while clock enable low");

endmodule : instrument_error_queue
`default_nettype wire

// file: verilog/error_queue_cfg.svh
`ifndef ERROR_QUEUE_CFG_SVH
`define ERROR_QUEUE_CFG_SVH
`define EQ_DEPTH         5'd20
`define EQ_CODE_W        10
`define EQ_MSG_W         8
`define EQ_CHAR_MAX      7'd80
`define EQ_CODE_NONE     10'sd0
`define EQ_CODE_OVERFLOW -10'sd350
`define EQ_MSG_NONE      8'h00
`define EQ_MSG_OVERFLOW  8'h01
`define EQ_PTR_RST       5'h00
`define EQ_EMPTY_RST     1'b1
`define EQ_CHAR_PAD      8'h20
`endif

// file: verilog/error_queue_pkg.sv
package error_queue_pkg;
  typedef logic signed [9:0] err_code_t;
  typedef logic [7:0]        msg_idx_t;
  typedef logic [4:0]        ptr_t;
  typedef logic [6:0]        len_t;
  typedef logic [7:0]        char_t;
endpackage : error_queue_pkg

// file: verilog/error_text_rom.sv
`timescale 1ns/1ps
`default_nettype none
`include "error_queue_cfg.svh"

module error_text_rom (
  input  wire logic [7:0] msg_idx_i,
  input  wire logic [6:0] char_pos_i,
  output logic      [7:0] char_o,
  output logic      [6:0] len_o
);

  // ==========================================================
  // message text tables, expanded at read-out
  localparam logic [8*16-1:0] TXT_NONE = "No error        ";
  localparam logic [8*16-1:0] TXT_OVFL = "Too many errors ";
  localparam logic [8*16-1:0] TXT_GEN  = "Device error    ";

  logic [8*16-1:0] txt;
  logic [6:0]      n;

  always_comb begin
    case (msg_idx_i)
      `EQ_MSG_NONE:     begin txt = TXT_NONE; n = 7'h08; end
      `EQ_MSG_OVERFLOW: begin txt = TXT_OVFL; n = 7'h0F; end
      default:          begin txt = TXT_GEN;  n = 7'h0C; end
    endcase
    len_o = (n > `EQ_CHAR_MAX) ? `EQ_CHAR_MAX : n;
    if (char_pos_i < n) begin
      char_o = txt[8*(15 - char_pos_i[3:0]) +: 8];
    end else begin
      char_o = `EQ_CHAR_PAD;
    end
  end

endmodule : error_text_rom
`default_nettype wire

// file: bench/host_poller.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// host side: one query per ask, answer taken while it stands
module host_poller (
  input  wire logic                       ref_clk_i,
  input  wire logic                       resp_valid_i,
  input  wire error_queue_pkg::err_code_t resp_code_i,
  input  wire error_queue_pkg::msg_idx_t  resp_msg_i,
  output logic                            query_o
);
  initial query_o = 1'b0;
  // polls only when told: it takes no notice of count_o or empty_o
  task automatic ask(output error_queue_pkg::err_code_t c,
                     output error_queue_pkg::msg_idx_t m, output bit ok);
    ok = 1'b0;
    @(negedge ref_clk_i);
    query_o = 1'b1;
    @(negedge ref_clk_i);
    query_o = 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      if (resp_valid_i === 1'b1) begin
        ok = 1'b1;
        c = resp_code_i;
        m = resp_msg_i;
      end else begin
        @(negedge ref_clk_i);
      end
    end
  endtask : ask
endmodule : host_poller
`default_nettype wire

// file: bench/instrument_error_queue_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "error_queue_cfg.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected %s expected %0d seen %0d", n, e, g); end end
module instrument_error_queue_tb;
  logic                       ref_clk_i, reset_n_i, err_valid_i, clear_status_i;
  logic                       reset_cmd_i, query, resp_valid_o, full_o, empty_o, clk_en;
  error_queue_pkg::err_code_t err_code_i, resp_code_o;
  error_queue_pkg::msg_idx_t  err_msg_i, resp_msg_o;
  logic [7:0]                 resp_char_o;
  logic [6:0]                 resp_len_o, char_pos;
  logic [4:0]                 count_o;
  int                         miscompares = 0;
  int                         comparisons = 0;
  // text itself is free; only its length and the padding beyond it are judged
  instrument_error_queue uut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .clk_en_i(clk_en), .err_valid_i(err_valid_i), .err_code_i(err_code_i),
    .err_msg_i(err_msg_i), .query_i(query), .clear_status_i(clear_status_i),
    .reset_cmd_i(reset_cmd_i), .char_pos_i(char_pos), .resp_valid_o(resp_valid_o),
    .resp_code_o(resp_code_o), .resp_msg_o(resp_msg_o), .resp_char_o(resp_char_o),
    .resp_len_o(resp_len_o), .count_o(count_o), .full_o(full_o), .empty_o(empty_o));
  host_poller host (.ref_clk_i(ref_clk_i), .resp_valid_i(resp_valid_o),
    .resp_code_i(resp_code_o), .resp_msg_i(resp_msg_o), .query_o(query));
  // ==========
  // shared tasks
  task automatic end_of_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic push(input int code);
    @(negedge ref_clk_i);
    err_valid_i = 1'b1;
    err_code_i  = error_queue_pkg::err_code_t'(code);
    err_msg_i   = 8'h02;
    @(negedge ref_clk_i);
    err_valid_i = 1'b0;
  endtask : push
  task automatic pulse(ref logic s);
    @(negedge ref_clk_i);
    s = 1'b1;
    @(negedge ref_clk_i);
    s = 1'b0;
  endtask : pulse
  task automatic pull(input int code, input error_queue_pkg::msg_idx_t msg);
    error_queue_pkg::err_code_t c;
    error_queue_pkg::msg_idx_t  m;
    bit                         ok;
    host.ask(c, m, ok);
    if (!ok) begin
      miscompares++;
      end_of_test();
    end
    `CHK("code", error_queue_pkg::err_code_t'(code), c)
    `CHK("msg", msg, m)
    @(negedge ref_clk_i);
    `CHK("len", 1'b1, resp_len_o <= `EQ_CHAR_MAX)
    `CHK("pad", `EQ_CHAR_PAD, resp_char_o)
  endtask : pull
  // ==========
  // scenarios
  task automatic fifo_order();
    for (int i = 1; i <= 3; i++) push(-100 - i);
    `CHK("count", 5'h03, count_o)
    for (int i = 1; i <= 3; i++) pull(-100 - i, 8'h02);
    `CHK("empty", 1'b1, empty_o)
    pull(`EQ_CODE_NONE, `EQ_MSG_NONE);
    $display("fifo_order done");
  endtask : fifo_order
  task automatic overflow();
    for (int i = 0; i <= 21; i++) push(-100 - i);
    `CHK("count", `EQ_DEPTH, count_o)
    `CHK("full", 1'b1, full_o)
    pull(-100, 8'h02);
    push(-200);
    `CHK("count", `EQ_DEPTH, count_o)
    for (int i = 1; i <= 18; i++) pull(-100 - i, 8'h02);
    pull(`EQ_CODE_OVERFLOW, `EQ_MSG_OVERFLOW);
    pull(-200, 8'h02);
    $display("overflow done");
  endtask : overflow
  task automatic commands();
    push(-1);
    push(-2);
    pulse(reset_cmd_i);
    `CHK("count", 5'h02, count_o)
    pull(-1, 8'h02);
    pulse(clear_status_i);
    `CHK("count", 5'h00, count_o)
    pull(`EQ_CODE_NONE, `EQ_MSG_NONE);
    push(-3);
    @(negedge ref_clk_i);
    reset_n_i = 1'b0;
    @(negedge ref_clk_i);
    reset_n_i = 1'b1;
    `CHK("count", 5'h00, count_o)
    `CHK("empty", 1'b1, empty_o)
    push(-4);
    pull(-4, 8'h02);
    $display("commands done");
  endtask : commands
  task automatic freeze();
    @(negedge ref_clk_i);
    clk_en = 1'b0;
    push(-5);
    `CHK("count", 5'h00, count_o)
    `CHK("empty", 1'b1, empty_o)
    clk_en = 1'b1;
    pull(`EQ_CODE_NONE, `EQ_MSG_NONE);
    $display("freeze done");
  endtask : freeze
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    {reset_n_i, err_valid_i, clear_status_i, reset_cmd_i} = 4'h0;
    err_code_i = 10'h000;
    err_msg_i  = 8'h00;
    clk_en     = 1'b1;
    char_pos   = 7'h7F;
    repeat (16) @(negedge ref_clk_i);
    reset_n_i = 1'b1;
    `CHK("empty", 1'b1, empty_o)
    fifo_order();
    overflow();
    commands();
    freeze();
    end_of_test();
  end
endmodule : instrument_error_queue_tb
`default_nettype wire
